// >>> logic/mdcwd_decoder.sv
// top of the multiplexed channel word decoder: host word in, eight channel codes out
// assumes: host word and strobe arrive from logic on the same clock; converters take codes
`timescale 1ns/10ps
module mdcwd_decoder (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       clkEn,
  input  wire logic [mdcwd_pkg::WORD_W-1:0] hostWord,
  input  wire logic                       hostWordValid,
  input  wire logic                       scanStart,
  output mdcwd_pkg::mdcwd_code_t          chanCode0,
  output mdcwd_pkg::mdcwd_code_t          chanCode1,
  output mdcwd_pkg::mdcwd_code_t          chanCode2,
  output mdcwd_pkg::mdcwd_code_t          chanCode3,
  output mdcwd_pkg::mdcwd_code_t          chanCode4,
  output mdcwd_pkg::mdcwd_code_t          chanCode5,
  output mdcwd_pkg::mdcwd_code_t          chanCode6,
  output mdcwd_pkg::mdcwd_code_t          chanCode7,
  output logic [mdcwd_pkg::NUM_CHAN-1:0]  chanStrobe,
  output logic                            outputsEnabled,
  output logic                            refreshBusy
);
  import mdcwd_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_REFRESH = 2'b01,
    ST_SETTLE  = 2'b10
  } mdcwd_state_t;

  typedef struct packed {
    mdcwd_state_t                st;
    logic [SEL_W-1:0]            rdIdx;
    logic [SEL_W-1:0]            outIdx;
    logic                        outValid;
    logic [3:0]                  wait_cnt;
    mdcwd_code_t [NUM_CHAN-1:0]  outCode;
    logic [NUM_CHAN-1:0]         strobe;
    logic                        enable;
    logic                        busy;
  } mdcwd_top_t;

  mdcwd_top_t state_reg;
  mdcwd_top_t state_next;

  // ------------------------------------------------------------
  // word field split
  // ------------------------------------------------------------
  mdcwd_code_t      wordCode;
  logic [SEL_W-1:0] wordSel;
  logic             wordEnable;
  logic             clearAll;
  logic             writeNow;
  mdcwd_code_t      rdData;

  assign wordCode   = hostWord[CODE_MSB:CODE_LSB];
  assign wordSel    = hostWord[SEL_MSB:SEL_LSB];
  assign wordEnable = hostWord[ENABLE_BIT];
  // a clear is only taken with a valid word, so idle garbage cannot blank the field
  assign clearAll   = hostWordValid && !wordEnable;
  assign writeNow   = hostWordValid && wordEnable;

  mdcwd_latch_bank u_bank (
    .clock    (clock),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .clearAll (clearAll),
    .wrEn     (writeNow),
    .wrAddr   (wordSel),
    .wrData   (wordCode),
    .rdAddr   (state_reg.rdIdx),
    .rdData   (rdData)
  );

  // ------------------------------------------------------------
  // refresh sequencer: walks all channels once per scan
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.strobe = '0;
    if (hostWordValid) begin
      state_next.enable = wordEnable;
    end
    case (state_reg.st)
      ST_IDLE: begin
        state_next.busy = 1'b0;
        if (scanStart) begin
          state_next.st       = ST_REFRESH;
          state_next.rdIdx    = '0;
          state_next.outValid = 1'b0;
          state_next.busy     = 1'b1;
        end
      end
      ST_REFRESH: begin
        // bank read is registered, so output lags the read index by one cycle
        state_next.outIdx   = state_reg.rdIdx;
        state_next.outValid = 1'b1;
        if (state_reg.rdIdx == SEL_W'(NUM_CHAN - 1)) begin
          state_next.st       = ST_SETTLE;
          state_next.wait_cnt = 4'(REFRESH_CYC);
        end else begin
          state_next.rdIdx = state_reg.rdIdx + 1'b1;
        end
      end
      ST_SETTLE: begin
        state_next.outValid = 1'b0;
        if (state_reg.wait_cnt <= 4'h1) begin
          state_next.st = ST_IDLE;
        end else begin
          state_next.wait_cnt = state_reg.wait_cnt - 4'h1;
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
    if (state_reg.outValid) begin
      state_next.outCode[state_reg.outIdx] = rdData;
      state_next.strobe[state_reg.outIdx]  = 1'b1;
    end
    // clear reaches the field at once, not at the next scan
    if (clearAll) begin
      state_next.outCode = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign chanCode0      = state_reg.outCode[0];
  assign chanCode1      = state_reg.outCode[1];
  assign chanCode2      = state_reg.outCode[2];
  assign chanCode3      = state_reg.outCode[3];
  assign chanCode4      = state_reg.outCode[4];
  assign chanCode5      = state_reg.outCode[5];
  assign chanCode6      = state_reg.outCode[6];
  assign chanCode7      = state_reg.outCode[7];
  assign chanStrobe     = state_reg.strobe;
  assign outputsEnabled = state_reg.enable;
  assign refreshBusy    = state_reg.busy;
endmodule : mdcwd_decoder

// >>> logic/mdcwd_latch_bank.sv
// holds the eight channel codes; read data come out of a register
// assumes: one write port, one read port, same clock as the decoder
`timescale 1ns/10ps
module mdcwd_latch_bank (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                clkEn,
  input  wire logic                clearAll,
  input  wire logic                wrEn,
  input  wire logic [2:0]          wrAddr,
  input  wire mdcwd_pkg::mdcwd_code_t wrData,
  input  wire logic [2:0]          rdAddr,
  output mdcwd_pkg::mdcwd_code_t   rdData
);
  import mdcwd_pkg::*;
  typedef struct packed {
    mdcwd_code_t [NUM_CHAN-1:0] mem;
    mdcwd_code_t                rd;
  } mdcwd_bank_t;
  mdcwd_bank_t state_reg;
  mdcwd_bank_t state_next;

  always_comb begin
    state_next = state_reg;
    // a clear also empties the read register, so no pre-clear code leaks out
    state_next.rd = clearAll ? CODE_RESET : state_reg.mem[rdAddr];
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (clearAll) begin
        state_next.mem[i] = CODE_RESET;
      end else if (wrEn && (wrAddr == i[2:0])) begin
        state_next.mem[i] = wrData;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign rdData = state_reg.rd;
endmodule : mdcwd_latch_bank

// >>> logic/mdcwd_pkg.sv
// package: word layout, channel count, code range and scan timing constants
// assumes: used by the channel word decoder and its latch array
package mdcwd_pkg;
  localparam int          WORD_W       = 16;
  localparam int          CODE_W       = 12;
  localparam int          SEL_W        = 3;
  localparam int          NUM_CHAN     = 8;
  localparam int          CODE_LSB     = 0;
  localparam int          CODE_MSB     = 11;
  localparam int          SEL_LSB      = 12;
  localparam int          SEL_MSB      = 14;
  localparam int          ENABLE_BIT   = 15;
  localparam logic [11:0] CODE_RESET   = 12'h000;
  localparam logic [11:0] CODE_MAX     = 12'hFFF;
  localparam int          OUT_LOW_UA   = 4000;
  localparam int          OUT_HIGH_UA  = 20000;
  localparam int          REFRESH_NS   = 40;
  localparam int          CLOCK_NS     = 10;
  localparam int          REFRESH_CYC  = (REFRESH_NS + CLOCK_NS - 1) / CLOCK_NS;
  typedef logic [CODE_W-1:0] mdcwd_code_t;
endpackage : mdcwd_pkg

// >>> tb/mdcwd_host.sv
// host model: writes words and paces scans
// assumes: tasks called from tb_top, driven at falling edges
`timescale 1ns/10ps
module mdcwd_host (
  input wire logic clock,
  output logic [15:0] hostWord,
  output logic     hostWordValid,
  output logic     scanStart
);
  initial begin
    hostWord = 16'h0000;
    hostWordValid = 1'b0;
    scanStart = 1'b0;
  end
  // enable, select, binary code in sixteen points
  task automatic put(input logic en, input logic [2:0] ch, input logic [11:0] code);
    @(negedge clock);
    hostWord = {en, ch, code};
    hostWordValid = 1'b1;
    @(negedge clock);
    hostWordValid = 1'b0;
    hostWord = ~hostWord; // no stale word left on the points
  endtask : put
  task automatic scan();
    @(negedge clock);
    scanStart = 1'b1;
    @(negedge clock);
    scanStart = 1'b0;
  endtask : scan
endmodule : mdcwd_host

// >>> tb/mdcwd_sva.sv
// checker: scan walk timing, clear and strobes of the decoder
// assumes: bound to mdcwd_decoder, one clock domain
`timescale 1ns/10ps
module mdcwd_sva (
  input wire logic             clock, rst_n, clkEn, hostWordValid, scanStart,
  input wire logic [15:0]      hostWord,
  input wire mdcwd_pkg::mdcwd_code_t chanCode0, chanCode3, chanCode7,
  input wire logic [7:0]       chanStrobe,
  input wire logic             outputsEnabled, refreshBusy
);
  import mdcwd_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire scanGo = scanStart && clkEn && !refreshBusy;
  wire wordTake = hostWordValid && clkEn;
  property p_go; scanGo |=> refreshBusy; endproperty
  a_go: assert property (p_go) else $error("no busy after scan");
  property p_walk; scanGo |-> ##3 chanStrobe[0] ##7 chanStrobe[7]; endproperty
  a_walk: assert property (p_walk) else $error("walk timing off");
  property p_step; chanStrobe[0] && clkEn |=> chanStrobe[1]; endproperty
  a_step: assert property (p_step) else $error("walk order off");
  property p_one; $onehot0(chanStrobe); endproperty
  a_one: assert property (p_one) else $error("two strobes");
  property p_quiet; chanStrobe != 8'h00 |-> refreshBusy; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe while idle");
  property p_clr; wordTake && !hostWord[15] |-> ##2 chanCode0 == 12'h000 && chanCode7 == 12'h000; endproperty
  a_clr: assert property (p_clr) else $error("codes not cleared");
  property p_off; wordTake && !hostWord[15] |-> ##[1:2] !outputsEnabled; endproperty
  a_off: assert property (p_off) else $error("enable stuck high");
  property p_on; wordTake && hostWord[15] |-> ##[1:2] outputsEnabled; endproperty
  a_on: assert property (p_on) else $error("enable stuck low");
  property p_hold; $changed(chanCode3) |-> chanStrobe[3] || chanCode3 == 12'h000; endproperty
  a_hold: assert property (p_hold) else $error("code moved unasked");
  c_scan: cover property (scanGo);
  c_clr: cover property (wordTake && !hostWord[15]);
  c_last: cover property (chanStrobe[7]);
endmodule : mdcwd_sva
bind mdcwd_decoder mdcwd_sva chk (.*);

// >>> tb/tb_top.sv
// testbench: host model drives words, every scan compared to expected latches
// assumes: package, design, checker and host model compiled first
`timescale 1ns/10ps
module tb_top;
  import mdcwd_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] hostWord;
  logic        hostWordValid, scanStart, outputsEnabled, refreshBusy;
  logic        clkEn = 1'b1;
  logic [7:0]  chanStrobe;
  mdcwd_code_t cc [8];
  mdcwd_code_t expCode [8] = '{default: 12'h000};
  int          errorCnt = 0;
  int          comparisons = 0;
  always #5 clock = ~clock;
  mdcwd_host host (.clock(clock), .hostWord(hostWord), .hostWordValid(hostWordValid), .scanStart(scanStart));
  mdcwd_decoder dut (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .hostWord(hostWord),
    .hostWordValid(hostWordValid), .scanStart(scanStart), .chanCode0(cc[0]), .chanCode1(cc[1]),
    .chanCode2(cc[2]), .chanCode3(cc[3]), .chanCode4(cc[4]), .chanCode5(cc[5]), .chanCode6(cc[6]),
    .chanCode7(cc[7]), .chanStrobe(chanStrobe), .outputsEnabled(outputsEnabled), .refreshBusy(refreshBusy));
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errorCnt, comparisons);
    if (errorCnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // bounded wait for the walk, then all eight channels compared
  task automatic run_scan();
    int n;
    host.scan();
    for (n = 0; n < 30 && (n < 2 || refreshBusy !== 1'b0); n++) @(negedge clock);
    if (n == 30) begin
      errorCnt++;
      report_and_stop();
    end
    for (int k = 0; k < 8; k++) check({4'h0, cc[k]}, {4'h0, expCode[k]});
  endtask : run_scan
  task automatic t_mux();
    for (int k = 0; k < 8; k++) begin
      expCode[k] = 12'hFFF >> k;
      host.put(1'b1, k[2:0], 12'hFFF >> k);
      run_scan();
    end
    check({15'h0, outputsEnabled}, 16'h0001);
  endtask : t_mux
  task automatic t_clear();
    host.put(1'b0, 3'h2, 12'hABC);
    @(negedge clock);
    check({15'h0, outputsEnabled}, 16'h0000);
    for (int k = 0; k < 8; k++) check({4'h0, cc[k]}, 16'h0000);
    expCode = '{default: 12'h000};
    run_scan();
  endtask : t_clear
  // several words in one scan, select order reversed
  task automatic t_ptr();
    for (int k = 0; k < 8; k++) begin
      expCode[7 - k] = 12'h800 >> k;
      host.put(1'b1, 3'h7 - k[2:0], 12'h800 >> k);
    end
    run_scan();
  endtask : t_ptr
  // clock enable low: word and scan both ignored
  task automatic t_freeze();
    @(negedge clock);
    clkEn = 1'b0;
    host.put(1'b1, 3'h0, 12'h123);
    host.scan();
    check({15'h0, refreshBusy}, 16'h0000);
    check({4'h0, cc[0]}, {4'h0, expCode[0]});
    clkEn = 1'b1;
    run_scan();
  endtask : t_freeze
  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    t_mux();
    t_clear();
    t_ptr();
    t_freeze();
    report_and_stop();
  end
endmodule : tb_top
